// file: hw/dspcg_pkg.sv
// constants and types shared by the deep-sleep port clock gating block
package dspcg_pkg;
  localparam int          NUM_PORTS       = 8;
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          MODE_W          = 2;
  // register byte offsets
  localparam logic [11:0] DS_GATE_OFFS    = 12'h128;
  localparam logic [11:0] FAULT_STAT_OFFS = 12'h130;
  localparam logic [11:0] FAULT_MASK_OFFS = 12'h134;
  localparam logic [11:0] CLK_STATE_OFFS  = 12'h138;
  // field layout: port enables sit in the low bits, the rest read as zero
  localparam int          PORT_LSB        = 0;
  localparam int          RSVD_LSB        = 8;
  localparam int          RSVD_MSB        = 31;
  // reset values
  localparam logic [7:0]  DS_GATE_RESET   = 8'h00;
  localparam logic [7:0]  FAULT_RESET     = 8'h00;
  localparam logic [7:0]  MASK_RESET      = 8'h00;
  localparam logic [7:0]  CLK_OFF_RESET   = 8'h00;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP  = 2'b10
  } dspcg_mode_t;
endpackage

// file: hw/dspcg_gate_sel.sv
// selects the port gating mask that is in force for the current power mode
`timescale 1ns/100ps
module dspcg_gate_sel #(
  parameter int N = dspcg_pkg::NUM_PORTS
) (
  input  wire logic [1:0]   sysMode,     // power mode code
  input  wire logic         autoSel,     // automatic gating select
  input  wire logic [N-1:0] runGate,     // run-mode enables
  input  wire logic [N-1:0] sleepGate,   // sleep-mode enables
  input  wire logic [N-1:0] deepGate,    // deep-sleep enables
  output logic      [N-1:0] effMask      // enables in force
);
  dspcg_pkg::dspcg_mode_t mode;

  always_comb begin
    mode = dspcg_pkg::dspcg_mode_t'(sysMode);
    effMask = runGate;
    if (autoSel) begin
      case (mode)
        dspcg_pkg::MODE_RUN:   effMask = runGate;
        dspcg_pkg::MODE_SLEEP: effMask = sleepGate;
        dspcg_pkg::MODE_DEEP:  effMask = deepGate;
        default:               effMask = runGate;
      endcase
    end
  end
endmodule

// file: hw/dspcg_fault_check.sv
// answers each port access with either a normal completion or a bus fault
`timescale 1ns/100ps
module dspcg_fault_check #(
  parameter int N  = dspcg_pkg::NUM_PORTS,
  parameter int IW = $clog2(N)
) (
  input  wire logic          clk,        // system clock
  input  wire logic          rst,        // synchronous reset, active high
  input  wire logic          accReq,     // port access request
  input  wire logic [IW-1:0] accIdx,     // target port
  input  wire logic [N-1:0]  portOn,     // current clock state per port
  output logic               accOk,      // normal completion pulse
  output logic               accFault,   // bus fault pulse
  output logic      [IW-1:0] faultIdx    // port of the most recent access
);
  always_ff @(posedge clk) begin
    if (rst) begin
      accOk    <= 1'b0;
      accFault <= 1'b0;
    end else begin
      accOk    <= accReq && portOn[accIdx];
      accFault <= accReq && !portOn[accIdx];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      faultIdx <= '0;
    end else if (accReq) begin
      faultIdx <= accIdx;
    end
  end
endmodule

// file: hw/dspcg_top.sv
// deep-sleep port clock gating: register, mode selection, fault answer and interrupt
`timescale 1ns/100ps
module dspcg_top #(
  parameter int NPORTS = dspcg_pkg::NUM_PORTS,
  parameter int IW     = $clog2(NPORTS)
) (
  input  wire logic              clk,          // 100 MHz system clock
  input  wire logic              rst,          // synchronous reset, active high
  input  wire logic [11:0]       addr,         // register byte address
  input  wire logic [31:0]       wrData,       // register write data
  input  wire logic              wrEn,         // write strobe
  input  wire logic              rdEn,         // read strobe
  output logic      [31:0]       rdData,       // read data, cycle after rdEn
  input  wire logic [1:0]        sysMode,      // power mode code
  input  wire logic              autoGateSel,  // automatic clock gating select
  input  wire logic [NPORTS-1:0] runGate,      // run-mode port enables
  input  wire logic [NPORTS-1:0] sleepGate,    // sleep-mode port enables
  input  wire logic              portAccReq,   // access to a port
  input  wire logic [IW-1:0]     portAccIdx,   // port addressed
  output logic                   portAccOk,    // access completed normally
  output logic                   portAccFault, // access answered with bus fault
  output logic      [NPORTS-1:0] portClockOn,  // per-port clock enable
  output logic                   irq           // level interrupt
);
  generate
    if (NPORTS < 2 || NPORTS > dspcg_pkg::RSVD_LSB) begin : g_bad_ports
      $error("dspcg_top: NPORTS must lie between 2 and 8");
    end
  endgenerate

  logic [NPORTS-1:0] deepSleepPortClockGate;
  logic [NPORTS-1:0] faultStat;
  logic [NPORTS-1:0] faultMask;
  logic [NPORTS-1:0] effMask;
  logic [IW-1:0]     faultIdx;
  logic [NPORTS-1:0] next_faultStat;
  logic [31:0]       next_rdData;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] offs);
    hit = (a == offs);
  endfunction

  function automatic logic [NPORTS-1:0] oneHot(input logic [IW-1:0] idx);
    oneHot = '0;
    oneHot[idx] = 1'b1;
  endfunction

  function automatic logic [31:0] widen(input logic [NPORTS-1:0] v);
    widen = dspcg_pkg::UNMAPPED_READ;
    widen[NPORTS-1:0] = v;
  endfunction

  // deep-sleep gating register; only the port bits are storage
  always_ff @(posedge clk) begin
    if (rst) begin
      deepSleepPortClockGate <= dspcg_pkg::DS_GATE_RESET[NPORTS-1:0];
    end else if (wrEn && hit(addr, dspcg_pkg::DS_GATE_OFFS)) begin
      deepSleepPortClockGate <= wrData[dspcg_pkg::PORT_LSB +: NPORTS];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      faultMask <= dspcg_pkg::MASK_RESET[NPORTS-1:0];
    end else if (wrEn && hit(addr, dspcg_pkg::FAULT_MASK_OFFS)) begin
      faultMask <= wrData[NPORTS-1:0];
    end
  end

  // a fault in the same cycle as its write-one-to-clear keeps the bit set
  always_comb begin
    next_faultStat = faultStat;
    if (wrEn && hit(addr, dspcg_pkg::FAULT_STAT_OFFS)) begin
      next_faultStat = next_faultStat & ~wrData[NPORTS-1:0];
    end
    if (portAccFault) begin
      next_faultStat = next_faultStat | oneHot(faultIdx);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      faultStat <= dspcg_pkg::FAULT_RESET[NPORTS-1:0];
    end else begin
      faultStat <= next_faultStat;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(faultStat & faultMask);
    end
  end

  // read mux; reserved and unmapped bits read as zero
  always_comb begin
    next_rdData = dspcg_pkg::UNMAPPED_READ;
    if (hit(addr, dspcg_pkg::DS_GATE_OFFS)) begin
      next_rdData = widen(deepSleepPortClockGate);
    end else if (hit(addr, dspcg_pkg::FAULT_STAT_OFFS)) begin
      next_rdData = widen(faultStat);
    end else if (hit(addr, dspcg_pkg::FAULT_MASK_OFFS)) begin
      next_rdData = widen(faultMask);
    end else if (hit(addr, dspcg_pkg::CLK_STATE_OFFS)) begin
      next_rdData = widen(portClockOn);
    end
  end

  // data is shown only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= dspcg_pkg::UNMAPPED_READ;
    end else if (rdEn) begin
      rdData <= next_rdData;
    end else begin
      rdData <= dspcg_pkg::UNMAPPED_READ;
    end
  end

  dspcg_gate_sel #(
    .N         (NPORTS)
  ) u_sel (
    .sysMode   (sysMode),
    .autoSel   (autoGateSel),
    .runGate   (runGate),
    .sleepGate (sleepGate),
    .deepGate  (deepSleepPortClockGate),
    .effMask   (effMask)
  );

  // the enable is a flop so a mode or mask change lands on a whole cycle;
  // ports use it as a clock enable rather than a gated clock
  always_ff @(posedge clk) begin
    if (rst) begin
      portClockOn <= dspcg_pkg::CLK_OFF_RESET[NPORTS-1:0];
    end else begin
      portClockOn <= effMask;
    end
  end

  dspcg_fault_check #(
    .N        (NPORTS),
    .IW       (IW)
  ) u_fault (
    .clk      (clk),
    .rst      (rst),
    .accReq   (portAccReq),
    .accIdx   (portAccIdx),
    .portOn   (portClockOn),
    .accOk    (portAccOk),
    .accFault (portAccFault),
    .faultIdx (faultIdx)
  );

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic deepAuto;
  logic sleepAuto;
  assign deepAuto  = autoGateSel && (sysMode == dspcg_pkg::MODE_DEEP);
  assign sleepAuto = autoGateSel && (sysMode == dspcg_pkg::MODE_SLEEP);

  sequence sWriteGate;
    wrEn && hit(addr, dspcg_pkg::DS_GATE_OFFS);
  endsequence

  sequence sReadGate;
    rdEn && hit(addr, dspcg_pkg::DS_GATE_OFFS);
  endsequence

  a_reset_all_off: assert property (disable iff (1'b0)
    rst |=> (portClockOn == '0) && (deepSleepPortClockGate == '0))
    else $error("ports not off after reset");

  a_deep_enables: assert property (
    deepAuto |=> portClockOn == $past(deepSleepPortClockGate))
    else $error("deep-sleep enable not applied");

  a_deep_gates_off: assert property (
    deepAuto |=> (portClockOn & ~$past(deepSleepPortClockGate)) == '0)
    else $error("cleared port still clocked in deep-sleep");

  a_sleep_own_mask: assert property (
    sleepAuto |=> portClockOn == $past(sleepGate))
    else $error("sleep mode not using its own mask");

  a_run_without_auto: assert property (
    !autoGateSel |=> portClockOn == $past(runGate))
    else $error("run mask not in force without auto gating");

  a_fault_on_off: assert property (
    portAccReq && !portClockOn[portAccIdx] |=> portAccFault && !portAccOk)
    else $error("access to unclocked port not faulted");

  a_ok_on_clocked: assert property (
    portAccReq && portClockOn[portAccIdx] |=> portAccOk && !portAccFault)
    else $error("access to clocked port faulted");

  a_reserved_zero: assert property (
    sReadGate |=> rdData[dspcg_pkg::RSVD_MSB:dspcg_pkg::RSVD_LSB] == '0)
    else $error("reserved bits not zero");

  a_bit_order: assert property (
    sWriteGate ##1 sReadGate |=> rdData[NPORTS-1:0] == $past(wrData[NPORTS-1:0], 2))
    else $error("enable bits not read back in place");

  a_edge_switch: assert property (
    !$stable(portClockOn) |-> portClockOn == $past(effMask))
    else $error("port enable changed off the clock edge");

  a_fault_sticky: assert property (
    portAccFault |=> faultStat[$past(faultIdx)])
    else $error("fault event lost");

  a_irq_level: assert property (
    |(faultStat & faultMask) |=> irq)
    else $error("interrupt not raised");

  // true while the bus address names one of the four registers
  logic mapped;
  assign mapped = hit(addr, dspcg_pkg::DS_GATE_OFFS) || hit(addr, dspcg_pkg::FAULT_STAT_OFFS) ||
                  hit(addr, dspcg_pkg::FAULT_MASK_OFFS) || hit(addr, dspcg_pkg::CLK_STATE_OFFS);

  a_reset_clears_rest: assert property (disable iff (1'b0)
    rst |=> (faultStat == '0) && (faultMask == '0) && !irq && (rdData == '0))
    else $error("status, mask or read data not cleared by reset");

  a_reset_no_answer: assert property (disable iff (1'b0)
    rst |=> !portAccOk && !portAccFault)
    else $error("access answered during reset");

  a_irq_low: assert property (
    (faultStat & faultMask) == '0 |=> !irq)
    else $error("interrupt raised with nothing pending");

  a_gate_write: assert property (
    sWriteGate |=> deepSleepPortClockGate == $past(wrData[NPORTS-1:0]))
    else $error("enable write not stored");

  // no enable may appear unless software wrote it
  a_gate_hold: assert property (
    !(wrEn && hit(addr, dspcg_pkg::DS_GATE_OFFS)) |=> $stable(deepSleepPortClockGate))
    else $error("enable register changed without a write");

  a_mask_write: assert property (
    wrEn && hit(addr, dspcg_pkg::FAULT_MASK_OFFS)
    |=> faultMask == $past(wrData[NPORTS-1:0]))
    else $error("mask write not stored");

  a_clear_one: assert property (
    wrEn && hit(addr, dspcg_pkg::FAULT_STAT_OFFS) && !portAccFault
    |=> (faultStat & $past(wrData[NPORTS-1:0])) == '0)
    else $error("write-one-to-clear left a bit set");

  a_no_stray_set: assert property (
    !portAccFault |=> (faultStat & ~$past(faultStat)) == '0)
    else $error("status bit set without a fault");

  a_set_wins: assert property (
    portAccFault && wrEn && hit(addr, dspcg_pkg::FAULT_STAT_OFFS)
    |=> faultStat[$past(faultIdx)])
    else $error("clear beat a simultaneous fault");

  a_idle_no_answer: assert property (
    !portAccReq |=> !portAccOk && !portAccFault)
    else $error("answer without an access");

  a_answer_excl: assert property (
    !(portAccOk && portAccFault))
    else $error("access answered both ways");

  a_idx_held: assert property (
    !portAccReq |=> $stable(faultIdx))
    else $error("fault port changed without an access");

  // mode code 11 is served as run
  a_auto_run: assert property (
    autoGateSel && (sysMode == dspcg_pkg::MODE_RUN || sysMode == 2'h3)
    |=> portClockOn == $past(runGate))
    else $error("run mask not used in run mode");

  a_rd_idle_zero: assert property (
    !rdEn |=> rdData == '0)
    else $error("read data shown without a read");

  a_unmapped_zero: assert property (
    rdEn && !mapped |=> rdData == '0)
    else $error("unmapped read not zero");

  a_stat_read: assert property (
    rdEn && hit(addr, dspcg_pkg::FAULT_STAT_OFFS)
    |=> rdData[NPORTS-1:0] == $past(faultStat))
    else $error("status read wrong");

  a_mask_read: assert property (
    rdEn && hit(addr, dspcg_pkg::FAULT_MASK_OFFS)
    |=> rdData[NPORTS-1:0] == $past(faultMask))
    else $error("mask read wrong");

  a_state_read: assert property (
    rdEn && hit(addr, dspcg_pkg::CLK_STATE_OFFS)
    |=> rdData[NPORTS-1:0] == $past(portClockOn))
    else $error("clock state read wrong");
endmodule

// file: testbench/tb_dspcg_top.sv
// self-checking testbench for the deep-sleep port clock gating block
`timescale 1ns/100ps
module tb_dspcg_top;
  logic        clk;
  logic        rst;
  logic [11:0] addr;
  logic [31:0] wrData;
  logic        wrEn;
  logic        rdEn;
  logic [31:0] rdData;
  logic [1:0]  sysMode;
  logic        autoGateSel;
  logic [7:0]  runGate;
  logic [7:0]  sleepGate;
  logic        portAccReq;
  logic [2:0]  portAccIdx;
  logic        portAccOk;
  logic        portAccFault;
  logic [7:0]  portClockOn;
  logic        irq;
  int          n_fail;
  int          checks_done;

  dspcg_top i_dut (
    .clk          (clk),
    .rst          (rst),
    .addr         (addr),
    .wrData       (wrData),
    .wrEn         (wrEn),
    .rdEn         (rdEn),
    .rdData       (rdData),
    .sysMode      (sysMode),
    .autoGateSel  (autoGateSel),
    .runGate      (runGate),
    .sleepGate    (sleepGate),
    .portAccReq   (portAccReq),
    .portAccIdx   (portAccIdx),
    .portAccOk    (portAccOk),
    .portAccFault (portAccFault),
    .portClockOn  (portClockOn),
    .irq          (irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wrEn   <= 1'b1;
    addr   <= a;
    wrData <= d;
    @(posedge clk);
    wrEn   <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 chk(rdData, exp);
  endtask

  // write and read back with no gap, as the bus allows
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clk);
    wrEn   <= 1'b1;
    addr   <= a;
    wrData <= d;
    @(posedge clk);
    wrEn   <= 1'b0;
    rdEn   <= 1'b1;
    @(posedge clk);
    rdEn   <= 1'b0;
    #1 chk(rdData, exp);
  endtask

  task automatic acc(input logic [2:0] idx, input logic ok);
    @(posedge clk);
    portAccReq <= 1'b1;
    portAccIdx <= idx;
    @(posedge clk);
    portAccReq <= 1'b0;
    #1 chk({portAccOk, portAccFault}, {ok, ~ok});
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic test_reset_values();
    chk(portClockOn, 32'h0000_0000);
    rd(dspcg_pkg::DS_GATE_OFFS, 32'h0000_0000);
    rd(dspcg_pkg::FAULT_STAT_OFFS, 32'h0000_0000);
    rd(dspcg_pkg::FAULT_MASK_OFFS, 32'h0000_0000);
    rd(dspcg_pkg::CLK_STATE_OFFS, 32'h0000_0000);
  endtask

  task automatic test_bit_map();
    @(posedge clk);
    sysMode     <= 2'b10;
    autoGateSel <= 1'b1;
    wr(dspcg_pkg::DS_GATE_OFFS, 32'hFFFF_FFA5);
    rd(dspcg_pkg::DS_GATE_OFFS, 32'h0000_00A5);
    settle();
    chk(portClockOn, 32'h0000_00A5);
    for (int i = 0; i < 8; i++) begin
      wr_rd(dspcg_pkg::DS_GATE_OFFS, 32'h0000_0001 << i, 32'h0000_0001 << i);
      settle();
      chk(portClockOn, 32'h0000_0001 << i);
    end
    wr(dspcg_pkg::DS_GATE_OFFS, 32'h0000_0000);
    settle();
    chk(portClockOn, 32'h0000_0000);
  endtask

  task automatic test_mode_select();
    logic [2:0] cfg [6];
    logic [7:0] exp [6];
    cfg = '{3'b001, 3'b011, 3'b101, 3'b111, 3'b010, 3'b100};
    exp = '{8'h3C, 8'hC3, 8'h5A, 8'h3C, 8'h3C, 8'h3C};
    @(posedge clk);
    runGate   <= 8'h3C;
    sleepGate <= 8'hC3;
    wr(dspcg_pkg::DS_GATE_OFFS, 32'h0000_005A);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      sysMode     <= cfg[i][2:1];
      autoGateSel <= cfg[i][0];
      settle();
      chk(portClockOn, exp[i]);
    end
    rd(dspcg_pkg::CLK_STATE_OFFS, 32'h0000_003C);
  endtask

  task automatic test_fault_irq();
    @(posedge clk);
    sysMode     <= 2'b10;
    autoGateSel <= 1'b1;
    wr(dspcg_pkg::DS_GATE_OFFS, 32'h0000_0001);
    settle();
    acc(3'd0, 1'b1);
    acc(3'd2, 1'b0);
    settle();
    rd(dspcg_pkg::FAULT_STAT_OFFS, 32'h0000_0004);
    chk(irq, 32'h0000_0000);
    wr(dspcg_pkg::FAULT_MASK_OFFS, 32'h0000_0004);
    settle();
    chk(irq, 32'h0000_0001);
    wr(dspcg_pkg::FAULT_STAT_OFFS, 32'h0000_0004);
    settle();
    chk(irq, 32'h0000_0000);
    rd(dspcg_pkg::FAULT_STAT_OFFS, 32'h0000_0000);
  endtask

  task automatic test_unmapped();
    // an unmapped write must not alias onto the gate register
    wr(12'h13C, 32'h0000_00FF);
    rd(12'h13C, dspcg_pkg::UNMAPPED_READ);
    rd(dspcg_pkg::DS_GATE_OFFS, 32'h0000_0001);
  endtask

  // reset in mid-run with every port enabled; held two edges so checks restart clean
  task automatic test_mid_reset();
    wr(dspcg_pkg::DS_GATE_OFFS, 32'h0000_00FF);
    settle();
    chk(portClockOn, 32'h0000_00FF);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(portClockOn, 32'h0000_0000);
    rd(dspcg_pkg::DS_GATE_OFFS, 32'h0000_0000);
    acc(3'd7, 1'b0);
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_fail++;
    complete_run();
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    rst = 1'b1;
    addr = 12'h000;
    wrData = 32'h0000_0000;
    wrEn = 1'b0;
    rdEn = 1'b0;
    sysMode = 2'b00;
    autoGateSel = 1'b0;
    runGate = 8'h00;
    sleepGate = 8'h00;
    portAccReq = 1'b0;
    portAccIdx = 3'd0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    test_reset_values();
    test_bit_map();
    test_mode_select();
    test_fault_irq();
    test_unmapped();
    test_mid_reset();
    complete_run();
  end
endmodule
